// ==== dv/spm_serial_dev.sv ====
`timescale 1ns/100ps
module spm_serial_dev (
    // Clock.
    input wire logic clk_in,
    // Pad controls from the mux, bit 0 is pin 0.5.
    input wire logic [2:0] pad_in,
    input wire logic [2:0] pad_oe_in,
    // Line driver of the external serial device.
    input wire logic [2:0] dev_en_in,
    input wire logic [2:0] dev_lvl_in,
    // Resolved wire levels and a sticky fight flag.
    output logic [2:0] wire_out,
    output logic clash_out
);
    // An idle serial line rests high, so a released pin is pulled up.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (pad_oe_in[i]) begin
                wire_out[i] = pad_in[i];
            end else if (dev_en_in[i]) begin
                wire_out[i] = dev_lvl_in[i];
            end else begin
                wire_out[i] = 1'b1;
            end
        end
    end

    // Both ends driving one pin would burn the pad; remember it.
    initial clash_out = 1'b0;
    always @(posedge clk_in) begin
        if (|(pad_oe_in & dev_en_in)) begin
            clash_out <= 1'b1;
        end
    end
endmodule : spm_serial_dev

// ==== dv/tb_spm_mux.sv ====
`timescale 1ns/100ps
module tb_spm_mux;
    import spm_pkg::*;
    logic clk_in, sys_rst_in, wr, rd, u0_tx, f2_tx, u0_rx, f2_rx, aux;
    logic ssn_n, clash, mosi;
    logic [3:0] spi_oe;
    logic [15:0] addr;
    logic [7:0] wdata, rdata;
    logic [2:0] pad, pad_oe, pin, dev_en, dev_lvl, g_out, g_oe, g_in, free;
    logic [6:0] cfg05, cfg06, cfg07;
    int errors, total_checks;

    spm_mux dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata),
        .p05_in(pin[0]), .p05_out(pad[0]), .p05_oe_out(pad_oe[0]),
        .p06_in(pin[1]), .p06_out(pad[1]), .p06_oe_out(pad_oe[1]),
        .p07_in(pin[2]), .p07_out(pad[2]), .p07_oe_out(pad_oe[2]),
        .p20_in(aux), .p20_out(), .p20_oe_out(spi_oe[2]), .p32_in(aux),
        .p32_out(), .p32_oe_out(), .p21_in(aux), .p21_out(),
        .p21_oe_out(spi_oe[0]), .p33_in(aux), .p33_out(),
        .p33_oe_out(spi_oe[1]), .p17_in(aux), .p17_out(),
        .p17_oe_out(spi_oe[3]), .p00_in(aux), .u0_tx_in(u0_tx),
        .u0_rx_out(u0_rx),
        .f2_tx_in(f2_tx), .f2_rx_out(f2_rx), .gpio_out_in(g_out),
        .gpio_oe_in(g_oe), .gpio_in_out(g_in), .key_pin_free_out(free),
        .io_cfg05_out(cfg05), .io_cfg06_out(cfg06), .io_cfg07_out(cfg07),
        .spi_mosi_in(aux), .spi_miso_in(aux), .spi_sck_in(aux),
        .spi_mosi_out(mosi), .spi_miso_out(), .spi_sck_out(),
        .spi_ssn_n_out(ssn_n));

    spm_serial_dev dev_u (.clk_in(clk_in), .pad_in(pad), .pad_oe_in(pad_oe),
        .dev_en_in(dev_en), .dev_lvl_in(dev_lvl), .wire_out(pin),
        .clash_out(clash));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stands only in the cycle after the strobe.
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        chk("read data", exp, rdata);
    endtask : rd_chk

    // Register to pad takes two edges, pin to receive three.
    task automatic settle;
        repeat (4) @(posedge clk_in);
        #1;
    endtask : settle

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        #1;
        chk("pad enables", 8'h00, {5'h0_0, pad_oe});
        chk("receive idle", 8'h03, {6'h0_0, u0_rx, f2_rx});
        chk("keys free", 8'h07, {5'h0_0, free});
        rd_chk(16'ha055, 8'h00);
        rd_chk(16'ha056, 8'h00);
        rd_chk(16'ha057, 8'h00);
    endtask : t_reset

    task automatic t_regs;
        wr_reg(16'ha055, 8'hee);
        wr_reg(16'ha057, 8'h5a);
        wr_reg(16'ha054, 8'h10);
        wr_reg(16'ha047, 8'hff);
        rd_chk(16'ha055, 8'hee);
        rd_chk(16'ha057, 8'h5a);
        rd_chk(16'ha054, 8'h00);
        rd_chk(16'ha047, 8'h7f);
        chk("cfg 0.7", 8'h7f, {1'b0, cfg07});
        wr_reg(16'ha055, 8'h00);
        wr_reg(16'ha057, 8'h00);
    endtask : t_regs

    task automatic t_serial_port_zero;
        wr_reg(16'ha045, 8'h06);
        wr_reg(16'ha055, 8'h10);
        wr_reg(16'ha056, 8'h10);
        settle();
        chk("cfg 0.5", 8'h06, {1'b0, cfg05});
        dev_en <= 3'b001;
        dev_lvl <= 3'b000;
        u0_tx <= 1'b0;
        settle();
        chk("serial zero rx", 8'h00, {7'h0_0, u0_rx});
        chk("pin 0.5 enable", 8'h00, {7'h0_0, pad_oe[0]});
        chk("pin 0.6 low", 8'h02, {6'h0_0, pad_oe[1], pad[1]});
        chk("keys free", 8'h04, {5'h0_0, free});
        u0_tx <= 1'b1;
        settle();
        chk("pin 0.6 high", 8'h03, {6'h0_0, pad_oe[1], pad[1]});
        dev_en <= 3'b000;
        wr_reg(16'ha055, 8'h00);
        wr_reg(16'ha056, 8'h00);
    endtask : t_serial_port_zero

    task automatic t_fifo;
        wr_reg(16'ha045, 8'ha0);
        wr_reg(16'ha046, 8'h06);
        wr_reg(16'ha055, 8'h08);
        wr_reg(16'ha056, 8'h18);
        wr_reg(16'ha057, 8'h08);
        settle();
        chk("cfg 0.5", 8'h20, {1'b0, cfg05});
        chk("cfg 0.6", 8'h06, {1'b0, cfg06});
        dev_en <= 3'b010;
        f2_tx <= 1'b0;
        settle();
        chk("fifo rx", 8'h00, {7'h0_0, f2_rx});
        chk("pin 0.6 enable", 8'h00, {7'h0_0, pad_oe[1]});
        chk("zero rx idle", 8'h01, {7'h0_0, u0_rx});
        chk("pin 0.7 low", 8'h02, {6'h0_0, pad_oe[2], pad[2]});
        chk("keys free", 8'h01, {5'h0_0, free});
        f2_tx <= 1'b1;
        settle();
        chk("pin 0.7 high", 8'h03, {6'h0_0, pad_oe[2], pad[2]});
        dev_en <= 3'b000;
        wr_reg(16'ha055, 8'h00);
        wr_reg(16'ha056, 8'h00);
    endtask : t_fifo

    task automatic t_gpio;
        wr_reg(16'ha055, 8'h01);
        wr_reg(16'ha057, 8'h01);
        g_out <= 3'b100;
        settle();
        chk("gpio high", 8'h03, {6'h0_0, pad_oe[2], pad[2]});
        chk("gpio 0.5 low", 8'h02, {6'h0_0, pad_oe[0], pad[0]});
        g_out <= 3'b000;
        settle();
        chk("gpio low", 8'h02, {6'h0_0, pad_oe[2], pad[2]});
        wr_reg(16'ha057, 8'h09);
        settle();
        chk("tx over gpio", 8'h03, {6'h0_0, pad_oe[2], pad[2]});
        wr_reg(16'ha057, 8'h00);
        wr_reg(16'ha055, 8'h00);
        settle();
        chk("released", 8'h00, {7'h0_0, pad_oe[2]});
        chk("pin levels", 8'h07, {5'h0_0, g_in});
    endtask : t_gpio

    task automatic t_spi;
        wr_reg(16'ha0f0, 8'h03);
        aux <= 1'b0;
        settle();
        chk("select slave", 8'h00, {7'h0_0, ssn_n});
        chk("slave pads", 8'h01, {4'h0, spi_oe});
        chk("slave mosi", 8'h00, {7'h0_0, mosi});
        wr_reg(16'ha0f0, 8'h01);
        settle();
        chk("select master", 8'h01, {7'h0_0, ssn_n});
        chk("master pads", 8'h04, {4'h0, spi_oe});
        chk("sck on 0.6", 8'h02, {6'h0_0, pad_oe[1], pad[1]});
        wr_reg(16'ha0f0, 8'h1d);
        settle();
        chk("alt pads", 8'h08, {4'h0, spi_oe});
        aux <= 1'b1;
    endtask : t_spi

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    // A hang cannot run on: the limit is far beyond the whole sequence.
    initial begin
        #400000;
        errors++;
        end_of_test();
    end

    initial begin
        sys_rst_in = 1'b1;
        {addr, wdata, wr, rd} = '0;
        {u0_tx, f2_tx, aux} = 3'b111;
        {dev_en, dev_lvl, g_out} = '0;
        g_oe = 3'b111;
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_regs();
        t_serial_port_zero();
        t_fifo();
        t_gpio();
        t_spi();
        chk("pin fight", 8'h00, {7'h0_0, clash});
        end_of_test();
    end
endmodule : tb_spm_mux

// ==== logic/spm_defs.svh ====
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define SPM_FN05_ADDR 16'ha055
`define SPM_FN06_ADDR 16'ha056
`define SPM_FN07_ADDR 16'ha057
`define SPM_IO05_ADDR 16'ha045
`define SPM_IO06_ADDR 16'ha046
`define SPM_IO07_ADDR 16'ha047
`define SPM_SPI_ADDR 16'ha0f0
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPM_FN_RST 8'h00
`define SPM_IO_RST 7'h00
`define SPM_SPI_RST 8'h00
`define SPM_RD_RST 8'h00
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPM_GPIO_BIT 0
`define SPM_RX2_BIT 3
`define SPM_TX2_BIT 3
`define SPM_RX0_BIT 4
`define SPM_TX0_BIT 4
`define SPM_SPI_EN_BIT 0
`define SPM_SPI_SLV_BIT 1
`define SPM_MISO_ALT_BIT 2
`define SPM_MOSI_ALT_BIT 3
`define SPM_SCK_ALT_BIT 4
// ----------------------------------------------------------------
// Synchroniser lanes
// ----------------------------------------------------------------
`define SPM_SYNC_W 9
`define SPM_S05 0
`define SPM_S06 1
`define SPM_S07 2
`define SPM_S20 3
`define SPM_S32 4
`define SPM_S21 5
`define SPM_S33 6
`define SPM_S17 7
`define SPM_S00 8
`endif

// ==== logic/spm_mux.sv ====
// Notes on behaviour
// RULE_01 - Pin 0.5 bit 4 routes serial-zero receive.
// RULE_02 - Pin 0.6 bit 4 drives serial-zero transmit.
// RULE_03 - Bit 0 enables general I/O, off.
// RULE_04 - Function registers: 8-bit, read/write, reset zero.
// RULE_05 - Pin 0.6 bit 3 routes fifo-port receive.
// RULE_06 - Pin 0.7 bit 3 drives fifo-port transmit.
// RULE_07 - Software sets serial-zero pin configuration first.
// RULE_08 - Software sets fifo-port pin configuration first.
// RULE_09 - Fifo-port pins shared with touch keys 5,6.
// RULE_10 - Configure shared pins before using fifo port.
// RULE_11 - SPI pins selectable among documented alternatives.
// RULE_12 - Slave select active low, slave mode only.
// RULE_13 - Separate seven-bit I/O configuration per pin.
// RULE_14 - Serial-zero pins shared with touch keys 4,5.
// RULE_15 - Fixed priority; never two drivers per pin.
// RULE_16 - Unrouted pin undriven; unrouted receive idles high.
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`include "spm_defs.svh"
module spm_mux (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Register port.
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Port pins 0.5, 0.6 and 0.7.
    input wire logic p05_in,
    output logic p05_out,
    output logic p05_oe_out,
    input wire logic p06_in,
    output logic p06_out,
    output logic p06_oe_out,
    input wire logic p07_in,
    output logic p07_out,
    output logic p07_oe_out,
    // SPI pins.
    input wire logic p20_in,
    output logic p20_out,
    output logic p20_oe_out,
    input wire logic p32_in,
    output logic p32_out,
    output logic p32_oe_out,
    input wire logic p21_in,
    output logic p21_out,
    output logic p21_oe_out,
    input wire logic p33_in,
    output logic p33_out,
    output logic p33_oe_out,
    input wire logic p17_in,
    output logic p17_out,
    output logic p17_oe_out,
    input wire logic p00_in,
    // Serial ports.
    input wire logic u0_tx_in,
    output logic u0_rx_out,
    input wire logic f2_tx_in,
    output logic f2_rx_out,
    // General I/O and touch-key sharing.
    input wire logic [2:0] gpio_out_in,
    input wire logic [2:0] gpio_oe_in,
    output logic [2:0] gpio_in_out,
    output logic [2:0] key_pin_free_out,
    // Pad electrical configuration.
    output logic [6:0] io_cfg05_out,
    output logic [6:0] io_cfg06_out,
    output logic [6:0] io_cfg07_out,
    // SPI engine.
    input wire logic spi_mosi_in,
    input wire logic spi_miso_in,
    input wire logic spi_sck_in,
    output logic spi_mosi_out,
    output logic spi_miso_out,
    output logic spi_sck_out,
    output logic spi_ssn_n_out
);
    import spm_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic fsel(input logic [7:0] cfg,
                                  input int unsigned pos);
        return cfg[pos];
    endfunction : fsel

    spm_state_t st;
    spm_state_t next_st;
    logic [`SPM_SYNC_W-1:0] pin_sync;
    spm_owner_t own05;
    spm_owner_t own06;
    spm_owner_t own07;
    logic spi_en;
    logic spi_slv;
    logic ssn_act;
    logic drv05, drv06, drv07;
    logic val05, val06, val07;
    logic drv20, drv32, drv21, drv33, drv17;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    spm_sync u_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .raw_in({p00_in, p17_in, p33_in, p21_in, p32_in, p20_in,
                 p07_in, p06_in, p05_in}),
        .sync_out(pin_sync)
    );

    // ----------------------------------------------------------------
    // Pin ownership
    // ----------------------------------------------------------------
    // Receive bits win over transmit bits, and peripherals win over
    // general I/O, so one pin never sees two drivers.
    always_comb begin
        spi_en = fsel(st.spi_sel, `SPM_SPI_EN_BIT);
        spi_slv = spi_en & fsel(st.spi_sel, `SPM_SPI_SLV_BIT);
        ssn_act = spi_slv & ~pin_sync[`SPM_S00]; // [RULE_12]
        if (fsel(st.fn05, `SPM_RX0_BIT)) begin // [RULE_01] [RULE_15]
            own05 = SPM_OWN_RX;
        end else if (fsel(st.fn05, `SPM_GPIO_BIT)) begin // [RULE_03]
            own05 = SPM_OWN_GPIO;
        end else begin
            own05 = SPM_OWN_NONE; // [RULE_16]
        end
        if (fsel(st.fn06, `SPM_RX2_BIT)) begin // [RULE_05] [RULE_15]
            own06 = SPM_OWN_RX;
        end else if (fsel(st.fn06, `SPM_TX0_BIT)) begin // [RULE_02]
            own06 = SPM_OWN_TX;
        end else if (spi_en
                     && !fsel(st.spi_sel, `SPM_SCK_ALT_BIT)) begin
            own06 = SPM_OWN_SCK; // [RULE_11]
        end else if (fsel(st.fn06, `SPM_GPIO_BIT)) begin // [RULE_03]
            own06 = SPM_OWN_GPIO;
        end else begin
            own06 = SPM_OWN_NONE; // [RULE_16]
        end
        if (fsel(st.fn07, `SPM_TX2_BIT)) begin // [RULE_06] [RULE_15]
            own07 = SPM_OWN_TX;
        end else if (fsel(st.fn07, `SPM_GPIO_BIT)) begin // [RULE_03]
            own07 = SPM_OWN_GPIO;
        end else begin
            own07 = SPM_OWN_NONE; // [RULE_16]
        end
    end

    // ----------------------------------------------------------------
    // Drive requests
    // ----------------------------------------------------------------
    // A receive owner leaves its pin released.
    always_comb begin
        drv05 = (own05 == SPM_OWN_GPIO) & gpio_oe_in[0];
        val05 = gpio_out_in[0];
        case (own06)
            SPM_OWN_TX: begin
                drv06 = 1'b1; // [RULE_02]
                val06 = u0_tx_in;
            end
            SPM_OWN_SCK: begin
                drv06 = ~spi_slv; // [RULE_11]
                val06 = spi_sck_in;
            end
            SPM_OWN_GPIO: begin
                drv06 = gpio_oe_in[1];
                val06 = gpio_out_in[1];
            end
            default: begin
                drv06 = 1'b0; // [RULE_16]
                val06 = 1'b0;
            end
        endcase
        case (own07)
            SPM_OWN_TX: begin
                drv07 = 1'b1; // [RULE_06]
                val07 = f2_tx_in;
            end
            SPM_OWN_GPIO: begin
                drv07 = gpio_oe_in[2];
                val07 = gpio_out_in[2];
            end
            default: begin
                drv07 = 1'b0; // [RULE_16]
                val07 = 1'b0;
            end
        endcase
        // Master drives MOSI and SCK; slave drives MISO when selected.
        drv20 = spi_en & ~spi_slv
              & ~fsel(st.spi_sel, `SPM_MOSI_ALT_BIT); // [RULE_11]
        drv32 = spi_en & ~spi_slv & fsel(st.spi_sel, `SPM_MOSI_ALT_BIT);
        drv21 = ssn_act & ~fsel(st.spi_sel, `SPM_MISO_ALT_BIT);
        drv33 = ssn_act & fsel(st.spi_sel, `SPM_MISO_ALT_BIT);
        drv17 = spi_en & ~spi_slv & fsel(st.spi_sel, `SPM_SCK_ALT_BIT);
    end

    // ----------------------------------------------------------------
    // Registers and routed inputs
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Register writes; only the low seven bits of I/O config exist.
        if (reg_wr_in) begin
            case (reg_addr_in)
                `SPM_FN05_ADDR: next_st.fn05 = reg_wdata_in; // [RULE_04]
                `SPM_FN06_ADDR: next_st.fn06 = reg_wdata_in;
                `SPM_FN07_ADDR: next_st.fn07 = reg_wdata_in;
                `SPM_IO05_ADDR: next_st.io05 = reg_wdata_in[6:0]; // [RULE_13]
                `SPM_IO06_ADDR: next_st.io06 = reg_wdata_in[6:0];
                `SPM_IO07_ADDR: next_st.io07 = reg_wdata_in[6:0];
                `SPM_SPI_ADDR: next_st.spi_sel = reg_wdata_in;
                default: next_st.spi_sel = st.spi_sel;
            endcase
        end
        // Read data stands for exactly one cycle; unmapped reads zero.
        next_st.rdata = `SPM_RD_RST;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `SPM_FN05_ADDR: next_st.rdata = st.fn05; // [RULE_04]
                `SPM_FN06_ADDR: next_st.rdata = st.fn06;
                `SPM_FN07_ADDR: next_st.rdata = st.fn07;
                `SPM_IO05_ADDR: next_st.rdata = {1'b0, st.io05};
                `SPM_IO06_ADDR: next_st.rdata = {1'b0, st.io06};
                `SPM_IO07_ADDR: next_st.rdata = {1'b0, st.io07};
                `SPM_SPI_ADDR: next_st.rdata = st.spi_sel;
                default: next_st.rdata = `SPM_RD_RST;
            endcase
        end
        // Receive lines idle high when no pin feeds them.
        next_st.u0_rx = (own05 == SPM_OWN_RX)
                      ? pin_sync[`SPM_S05] : 1'b1; // [RULE_01] [RULE_16]
        next_st.f2_rx = (own06 == SPM_OWN_RX)
                      ? pin_sync[`SPM_S06] : 1'b1; // [RULE_05] [RULE_16]
        next_st.gpio_in = pin_sync[`SPM_S07:`SPM_S05];
        // A key may sense its pin only while no function holds it.
        next_st.key_free = {own07 == SPM_OWN_NONE,
                            own06 == SPM_OWN_NONE,
                            own05 == SPM_OWN_NONE}; // [RULE_09] [RULE_14]
        next_st.spi_mosi = 1'b1;
        next_st.spi_sck = 1'b0;
        next_st.spi_miso = 1'b1;
        if (spi_slv) begin
            next_st.spi_mosi = fsel(st.spi_sel, `SPM_MOSI_ALT_BIT)
                             ? pin_sync[`SPM_S32] : pin_sync[`SPM_S20];
            next_st.spi_sck = fsel(st.spi_sel, `SPM_SCK_ALT_BIT)
                            ? pin_sync[`SPM_S17] : pin_sync[`SPM_S06];
        end else if (spi_en) begin
            next_st.spi_miso = fsel(st.spi_sel, `SPM_MISO_ALT_BIT)
                             ? pin_sync[`SPM_S33] : pin_sync[`SPM_S21];
        end
        // Slave select is meaningless to a master and reads inactive.
        next_st.spi_ssn_n = spi_slv ? pin_sync[`SPM_S00] : 1'b1; // [RULE_12]
    end

    // Register state; every function starts disabled.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st <= '0;
            st.u0_rx <= 1'b1;
            st.f2_rx <= 1'b1;
            st.key_free <= 3'h7;
            st.spi_mosi <= 1'b1;
            st.spi_miso <= 1'b1;
            st.spi_ssn_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Pad drivers
    // ----------------------------------------------------------------
    spm_pad u_p05 (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .drv_in(drv05), .val_in(val05),
        .pad_out(p05_out), .pad_oe_out(p05_oe_out));
    spm_pad u_p06 (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .drv_in(drv06), .val_in(val06),
        .pad_out(p06_out), .pad_oe_out(p06_oe_out));
    spm_pad u_p07 (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .drv_in(drv07), .val_in(val07),
        .pad_out(p07_out), .pad_oe_out(p07_oe_out));
    spm_pad u_p20 (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .drv_in(drv20), .val_in(spi_mosi_in),
        .pad_out(p20_out), .pad_oe_out(p20_oe_out));
    spm_pad u_p32 (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .drv_in(drv32), .val_in(spi_mosi_in),
        .pad_out(p32_out), .pad_oe_out(p32_oe_out));
    spm_pad u_p21 (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .drv_in(drv21), .val_in(spi_miso_in),
        .pad_out(p21_out), .pad_oe_out(p21_oe_out));
    spm_pad u_p33 (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .drv_in(drv33), .val_in(spi_miso_in),
        .pad_out(p33_out), .pad_oe_out(p33_oe_out));
    spm_pad u_p17 (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .drv_in(drv17), .val_in(spi_sck_in),
        .pad_out(p17_out), .pad_oe_out(p17_oe_out));

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata_out = st.rdata;
    assign u0_rx_out = st.u0_rx;
    assign f2_rx_out = st.f2_rx;
    assign gpio_in_out = st.gpio_in;
    assign key_pin_free_out = st.key_free;
    assign io_cfg05_out = st.io05; // [RULE_13]
    assign io_cfg06_out = st.io06;
    assign io_cfg07_out = st.io07;
    assign spi_mosi_out = st.spi_mosi;
    assign spi_miso_out = st.spi_miso;
    assign spi_sck_out = st.spi_sck;
    assign spi_ssn_n_out = st.spi_ssn_n;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    a_reset_clears_fn: assert property ( // [RULE_04]
        $past(sys_rst_in) |-> st.fn05 == 8'h00 && st.fn06 == 8'h00
            && st.fn07 == 8'h00 && !p06_oe_out)
        else $error("function registers not zero after reset");
    a_rx0_follow: assert property ( // [RULE_01]
        st.fn05[4] |=> u0_rx_out == $past(pin_sync[0]))
        else $error("serial-zero receive does not follow pin 0.5");
    a_rx0_idle_high: assert property ( // [RULE_16]
        !st.fn05[4] |=> u0_rx_out)
        else $error("unrouted serial-zero receive not high");
    a_tx0_drives_pin: assert property ( // [RULE_02]
        st.fn06 == 8'h10 |=> p06_oe_out && p06_out == $past(u0_tx_in))
        else $error("pin 0.6 not driven by serial-zero transmit");
    a_rx2_no_drive: assert property ( // [RULE_05]
        st.fn06[3] |=> !p06_oe_out && f2_rx_out == $past(pin_sync[1])
            && !key_pin_free_out[1])
        else $error("pin 0.6 receive route wrong");
    a_tx2_drives_pin: assert property ( // [RULE_06]
        st.fn07[3] |=> p07_oe_out && p07_out == $past(f2_tx_in))
        else $error("pin 0.7 not driven by fifo transmit");
    a_gpio_only: assert property ( // [RULE_03]
        st.fn05 == 8'h01 |=> p05_oe_out == $past(gpio_oe_in[0]))
        else $error("general I/O enable not honoured on pin 0.5");
    a_pin07_released: assert property ( // [RULE_16]
        !st.fn07[3] && !st.fn07[0] ##1 !st.fn07[3] && !st.fn07[0]
            |=> !p07_oe_out [*1] ##1 1'b1)
        else $error("pin 0.7 driven with no function");
    a_read_back: assert property ( // [RULE_04]
        reg_rd_in && reg_addr_in == 16'ha056
            |=> reg_rdata_out == $past(st.fn06) ##1 reg_rdata_out == 8'h00
            || $past(reg_rd_in))
        else $error("function register read back wrong");
    a_ssn_master: assert property ( // [RULE_12]
        !st.spi_sel[1] |=> spi_ssn_n_out && !p21_oe_out && !p33_oe_out)
        else $error("slave select honoured outside slave mode");

    c_tx0_route: cover property (st.fn06 == 8'h10 ##1 p06_oe_out);
    c_rx2_route: cover property (st.fn06[3] && st.fn07[3]);
    c_spi_slave: cover property (st.spi_sel[1:0] == 2'b11 && p21_oe_out);
    c_gpio_out: cover property (st.fn07 == 8'h01 && p07_oe_out);
endmodule : spm_mux

// ==== logic/spm_pad.sv ====
`timescale 1ns/100ps
module spm_pad (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Drive request from the routing logic.
    input wire logic drv_in,
    input wire logic val_in,
    // Registered pad controls.
    output logic pad_out,
    output logic pad_oe_out
);
    import spm_pkg::*;
    spm_pad_t st;
    spm_pad_t next_st;

    // Value is parked low while the pad is released.
    always_comb begin
        next_st.oe = drv_in;
        next_st.val = drv_in & val_in;
    end

    // Pads come out of reset released.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pad_out = st.val;
    assign pad_oe_out = st.oe;
endmodule : spm_pad

// ==== logic/spm_pkg.sv ====
`include "spm_defs.svh"
package spm_pkg;
    // Owner of a shared pin, one-hot.
    typedef enum logic [4:0] {
        SPM_OWN_NONE = 5'h01,
        SPM_OWN_RX   = 5'h02,
        SPM_OWN_TX   = 5'h04,
        SPM_OWN_SCK  = 5'h08,
        SPM_OWN_GPIO = 5'h10
    } spm_owner_t;

    typedef struct packed {
        logic [7:0] fn05;
        logic [7:0] fn06;
        logic [7:0] fn07;
        logic [6:0] io05;
        logic [6:0] io06;
        logic [6:0] io07;
        logic [7:0] spi_sel;
        logic [7:0] rdata;
        logic u0_rx;
        logic f2_rx;
        logic [2:0] gpio_in;
        logic [2:0] key_free;
        logic spi_mosi;
        logic spi_miso;
        logic spi_sck;
        logic spi_ssn_n;
    } spm_state_t;

    typedef struct packed {
        logic [`SPM_SYNC_W-1:0] s1;
        logic [`SPM_SYNC_W-1:0] s2;
    } spm_sync_t;

    typedef struct packed {
        logic val;
        logic oe;
    } spm_pad_t;
endpackage : spm_pkg

// ==== logic/spm_sync.sv ====
`timescale 1ns/100ps
`include "spm_defs.svh"
module spm_sync (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Raw pin levels and their synchronised copies.
    input wire logic [`SPM_SYNC_W-1:0] raw_in,
    output logic [`SPM_SYNC_W-1:0] sync_out
);
    import spm_pkg::*;
    spm_sync_t st;
    spm_sync_t next_st;

    // First stage feeds only the second; idle level of a line is high.
    always_comb begin
        next_st = st;
        next_st.s1 = raw_in;
        next_st.s2 = st.s1;
    end

    // Both stages reset to the idle level.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.s2;
endmodule : spm_sync
